/* design/pbmux_regs.vh */
// register map, field positions, reset values and clock-select codes of the port b function mux
`ifndef PBMUX_REGS_VH
`define PBMUX_REGS_VH
// register byte offsets
`define PBMUX_PORT_DATA     8'h00
`define PBMUX_PORT_DIR      8'h04
`define PBMUX_PIN_IN        8'h08
`define PBMUX_IRQ_MASK      8'h0c
`define PBMUX_TIMER_CTRL    8'h10
`define PBMUX_TIMER_ONE     8'h14
`define PBMUX_CLOCK_CFG     8'h18
`define PBMUX_STATUS        8'h1c
`define PBMUX_PIN_FLAGS     8'h20
// general_irq_mask_reg fields
`define PBMUX_IRQ_GLOBAL    0
`define PBMUX_IRQ_GRP_ZERO  4
`define PBMUX_IRQ_GRP_ONE   5
`define PBMUX_IRQ_EXT_ZERO  6
// timer_zero_control_reg fields
`define PBMUX_TMR_CS1       1
`define PBMUX_TMR_CS2       2
`define PBMUX_TMR_LOWLEVEL  3
// timer one control fields
`define PBMUX_T1_OC_A       0
`define PBMUX_T1_OC_B       1
`define PBMUX_T1_PWM_A      2
`define PBMUX_T1_PWM_B      3
`define PBMUX_T1_USI        4
// clock config: clock source codes, reset-disable fuse bit
`define PBMUX_CLK_FIELD_W   2
`define PBMUX_CLK_RC        2'h0
`define PBMUX_CLK_EXT       2'h1
`define PBMUX_CLK_PLL       2'h2
`define PBMUX_CLK_XTAL      2'h3
`define PBMUX_CFG_FUSE      4
// status fields
`define PBMUX_ST_SLEEP      0
`define PBMUX_ST_GRP0_FLAG  1
`define PBMUX_ST_GRP1_FLAG  2
// reset values
`define PBMUX_RST_BYTE      8'h00
`define PBMUX_RST_CLKCFG    8'h10
// synchroniser reset: reset pin idles high, so no false reset after release
`define PBMUX_RST_SYNC      8'h80
// axi responses
`define PBMUX_RESP_OKAY     2'h0
`define PBMUX_RESP_SLVERR   2'h2
`endif

/* design/pbmux_top.v */
// port b alternate-function mux with axi4-lite register access
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "pbmux_regs.vh"

module pbmux_top (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // port pins
    input  wire [7:0]  pin_in,
    output reg  [7:0]  pin_out,
    output reg  [7:0]  pin_oe,
    output reg  [7:0]  pin_pullup,
    // peripheral side
    input  wire        sleep_mode,
    input  wire        timer_one_compare_a_out,
    input  wire        timer_one_compare_b_out,
    input  wire        usi_clock_out,
    input  wire        usi_data_out,
    output reg         external_irq_zero,
    output reg         timer_zero_ext_clock,
    output reg         usi_serial_in,
    output reg         ext_reset_n,
    output reg         pin_change_group_zero,
    output reg         pin_change_group_one,
    output reg  [7:0]  digital_in_enable
);

////////////////////////////////////////////////////////////////////////////////
// registers
reg [7:0] port_data;
reg [7:0] port_dir;
reg [7:0] general_irq_mask_reg;
reg [7:0] timer_zero_control_reg;
reg [7:0] timer_one_ctrl;
reg [7:0] clock_cfg;
reg [7:0] pin_flags;
reg [7:0] sync_a;
reg [7:0] sync_b;
reg [7:0] sync_c;
reg [7:0] pin_level;
reg [7:0] aw_addr;
reg       aw_held;
reg [31:0] w_data;
reg [3:0] w_strb;
reg       w_held;

wire [7:0] next_pin_level;
wire [7:0] pin_edge;

////////////////////////////////////////////////////////////////////////////////
// alternate-function decode
wire reset_pin_disable_fuse = clock_cfg[`PBMUX_CFG_FUSE];
wire [1:0] clk_src = clock_cfg[`PBMUX_CLK_FIELD_W-1:0];
wire reset_use = reset_pin_disable_fuse;
wire timer_zero_clksel_bit2 = timer_zero_control_reg[`PBMUX_TMR_CS2];
wire timer_zero_clksel_bit1 = timer_zero_control_reg[`PBMUX_TMR_CS1];
wire t0_clk_use = timer_zero_clksel_bit2 & timer_zero_clksel_bit1;
wire external_irq_zero_use = general_irq_mask_reg[`PBMUX_IRQ_EXT_ZERO];
wire external_irq_zero_low = external_irq_zero_use & timer_zero_control_reg[`PBMUX_TMR_LOWLEVEL];
wire osc_out_use = (clk_src == `PBMUX_CLK_XTAL);
wire osc_in_use = (clk_src == `PBMUX_CLK_XTAL) | (clk_src == `PBMUX_CLK_EXT);
wire usi_on = timer_one_ctrl[`PBMUX_T1_USI];
wire oc_b_use = timer_one_ctrl[`PBMUX_T1_OC_B] | timer_one_ctrl[`PBMUX_T1_PWM_B];
wire oc_a_use = timer_one_ctrl[`PBMUX_T1_OC_A] | timer_one_ctrl[`PBMUX_T1_PWM_A];
wire inv_b_use = timer_one_ctrl[`PBMUX_T1_PWM_B] & ~usi_on;
wire inv_a_use = timer_one_ctrl[`PBMUX_T1_PWM_A] & ~usi_on;

// per-pin mask of pin change by an active alternate function
wire [7:0] pc_mask = {reset_use,
                      external_irq_zero_low | t0_clk_use,
                      osc_out_use,
                      osc_in_use,
                      oc_b_use & port_dir[3],
                      inv_b_use | usi_on,
                      oc_a_use | usi_on,
                      inv_a_use | usi_on};
wire global_en = general_irq_mask_reg[`PBMUX_IRQ_GLOBAL];
wire [7:0] grp_en = {{4{general_irq_mask_reg[`PBMUX_IRQ_GRP_ONE]}},
                     {4{general_irq_mask_reg[`PBMUX_IRQ_GRP_ZERO]}}};
wire [7:0] pc_en = {8{global_en}} & grp_en & ~pc_mask;

// digital input enable: off under reset use, kept on in sleep when needed
wire [7:0] next_die;
assign next_die[7] = ~reset_use & (~sleep_mode | pc_en[7]);
assign next_die[6] = ~sleep_mode | pc_en[6] | external_irq_zero_use | t0_clk_use;
assign next_die[5] = ~osc_out_use & (~sleep_mode | pc_en[5]);
assign next_die[4] = ~osc_in_use & (~sleep_mode | pc_en[4]) | (clk_src == `PBMUX_CLK_EXT);
assign next_die[3:0] = ~{4{sleep_mode}} | pc_en[3:0];

// output overrides; pwm and compare use the direction bit as set by software
reg [7:0] next_out;
reg [7:0] next_oe;
reg [7:0] next_pu;
always @* begin
    next_out = port_data;
    next_oe  = port_dir;
    next_pu  = port_data & ~port_dir;
    if (reset_use) begin
        next_oe[7] = 1'b0;
        next_pu[7] = 1'b1;
    end
    if (osc_out_use) begin
        next_oe[5] = 1'b0;
        next_pu[5] = 1'b0;
    end
    if (osc_in_use) begin
        next_oe[4] = 1'b0;
        next_pu[4] = 1'b0;
    end
    if (oc_b_use)
        next_out[3] = timer_one_compare_b_out;
    if (usi_on) begin
        next_out[2] = usi_clock_out;
        next_out[1] = usi_data_out;
    end else begin
        if (inv_b_use)
            next_out[2] = ~timer_one_compare_b_out;
        if (oc_a_use)
            next_out[1] = timer_one_compare_a_out;
        if (inv_a_use)
            next_out[0] = ~timer_one_compare_a_out;
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin synchroniser: change counts when second and third stages agree
assign next_pin_level = ((sync_b == sync_c) ? sync_b : pin_level) & next_die;
// an input buffer switching on is not a pin change
assign pin_edge = (next_pin_level ^ pin_level) & pc_en & digital_in_enable;

always @(posedge aclk) begin
    if (!aresetn) begin
        sync_a    <= `PBMUX_RST_SYNC;
        sync_b    <= `PBMUX_RST_SYNC;
        sync_c    <= `PBMUX_RST_SYNC;
        pin_level <= `PBMUX_RST_BYTE;
    end else begin
        sync_a    <= pin_in;
        sync_b    <= sync_a;
        sync_c    <= sync_b;
        pin_level <= next_pin_level;
    end
end

////////////////////////////////////////////////////////////////////////////////
// outputs to pins and peripherals
always @(posedge aclk) begin
    if (!aresetn) begin
        pin_out               <= `PBMUX_RST_BYTE;
        pin_oe                <= `PBMUX_RST_BYTE;
        pin_pullup            <= `PBMUX_RST_BYTE;
        digital_in_enable     <= `PBMUX_RST_BYTE;
        external_irq_zero     <= 1'b0;
        timer_zero_ext_clock  <= 1'b0;
        usi_serial_in         <= 1'b0;
        ext_reset_n           <= 1'b1;
        pin_change_group_zero <= 1'b0;
        pin_change_group_one  <= 1'b0;
    end else begin
        pin_out               <= next_out;
        pin_oe                <= next_oe;
        pin_pullup            <= next_pu;
        digital_in_enable     <= next_die;
        external_irq_zero     <= external_irq_zero_use & pin_level[6];
        timer_zero_ext_clock  <= t0_clk_use & pin_level[6];
        usi_serial_in         <= pin_level[0];
        ext_reset_n           <= reset_use ? sync_c[7] : 1'b1;
        pin_change_group_zero <= |pin_edge[3:0];
        pin_change_group_one  <= |pin_edge[7:4];
    end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave: address and data taken in either order, answer next cycle
wire wr_go = aw_held & w_held & ~s_axi_bvalid;
wire [7:0] wr_mask = {{4{w_strb[0]}}, {4{w_strb[0]}}};
wire wr_map = (aw_addr <= `PBMUX_PIN_FLAGS) && (aw_addr[1:0] == 2'h0) && (aw_addr != `PBMUX_PIN_IN)
              && (aw_addr != `PBMUX_STATUS);
reg [7:0] rd_byte;
reg       rd_ok;
always @* begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
        `PBMUX_PORT_DATA:  rd_byte = port_data;
        `PBMUX_PORT_DIR:   rd_byte = port_dir;
        `PBMUX_PIN_IN:     rd_byte = pin_level;
        `PBMUX_IRQ_MASK:   rd_byte = general_irq_mask_reg;
        `PBMUX_TIMER_CTRL: rd_byte = timer_zero_control_reg;
        `PBMUX_TIMER_ONE:  rd_byte = timer_one_ctrl;
        `PBMUX_CLOCK_CFG:  rd_byte = clock_cfg;
        `PBMUX_STATUS:     rd_byte = {5'h00, |pin_flags[7:4], |pin_flags[3:0], sleep_mode};
        `PBMUX_PIN_FLAGS:  rd_byte = pin_flags;
        default: begin
            rd_byte = `PBMUX_RST_BYTE;
            rd_ok   = 1'b0;
        end
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready          <= 1'b0;
        s_axi_wready           <= 1'b0;
        s_axi_bvalid           <= 1'b0;
        s_axi_bresp            <= `PBMUX_RESP_OKAY;
        s_axi_arready          <= 1'b0;
        s_axi_rvalid           <= 1'b0;
        s_axi_rresp            <= `PBMUX_RESP_OKAY;
        s_axi_rdata            <= 32'h0000_0000;
        aw_held                <= 1'b0;
        w_held                 <= 1'b0;
        aw_addr                <= 8'h00;
        w_data                 <= 32'h0000_0000;
        w_strb                 <= 4'h0;
        port_data              <= `PBMUX_RST_BYTE;
        port_dir               <= `PBMUX_RST_BYTE;
        general_irq_mask_reg   <= `PBMUX_RST_BYTE;
        timer_zero_control_reg <= `PBMUX_RST_BYTE;
        timer_one_ctrl         <= `PBMUX_RST_BYTE;
        clock_cfg              <= `PBMUX_RST_CLKCFG;
        pin_flags              <= `PBMUX_RST_BYTE;
    end else begin
        s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
        s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
        if (s_axi_awvalid & s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        // sticky per-pin flags; a new edge wins over a write-one clear
        pin_flags <= (pin_flags & ~((wr_go && aw_addr == `PBMUX_PIN_FLAGS && w_strb[0]) ?
                     w_data[7:0] : 8'h00)) | pin_edge;
        if (wr_go) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? `PBMUX_RESP_OKAY : `PBMUX_RESP_SLVERR;
            if (w_strb[0]) begin
                case (aw_addr)
                    `PBMUX_PORT_DATA:  port_data <= w_data[7:0];
                    `PBMUX_PORT_DIR:   port_dir <= w_data[7:0];
                    `PBMUX_IRQ_MASK:   general_irq_mask_reg <= w_data[7:0];
                    `PBMUX_TIMER_CTRL: timer_zero_control_reg <= w_data[7:0];
                    `PBMUX_TIMER_ONE:  timer_one_ctrl <= w_data[7:0];
                    `PBMUX_CLOCK_CFG:  clock_cfg <= w_data[7:0] & wr_mask | 8'h00;
                    default: ;
                endcase
            end
        end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
        if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_byte};
            s_axi_rresp  <= rd_ok ? `PBMUX_RESP_OKAY : `PBMUX_RESP_SLVERR;
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule // pbmux_top

/* dv/pbmux_properties.sv */
// port-level assertions for the port b function mux
`timescale 1ns/1ps
module pbmux_properties (
    // clock and reset
    input wire        aclk,
    input wire        aresetn,
    // register bus
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // pins and peripherals
    input wire [7:0]  pin_in,
    input wire [7:0]  pin_oe,
    input wire [7:0]  pin_pullup,
    input wire [7:0]  digital_in_enable,
    input wire        ext_reset_n,
    input wire        external_irq_zero,
    input wire        timer_zero_ext_clock,
    input wire        pin_change_group_zero,
    input wire        pin_change_group_one
);
////////////////////////////////////////////////////////////
// pin history, deep enough to cover the synchroniser delay
reg [7:0] prev_in;
reg [6:0] chg0, chg1, p7lo, p6hi;
always @(posedge aclk) begin
    prev_in <= pin_in;
    if (!aresetn) begin
        chg0 <= 7'h00;
        chg1 <= 7'h00;
        p7lo <= {7{~pin_in[7]}};
        p6hi <= {7{pin_in[6]}};
    end else begin
        chg0 <= {chg0[5:0], prev_in[3:0] != pin_in[3:0]};
        chg1 <= {chg1[5:0], prev_in[7:4] != pin_in[7:4]};
        p7lo <= {p7lo[5:0], ~pin_in[7]};
        p6hi <= {p6hi[5:0], pin_in[6]};
    end
end
////////////////////////////////////////////////////////////
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
sequence s_after0; (|chg0[6:1]) ##1 !pin_change_group_zero; endsequence
sequence s_after1; (|chg1[6:1]) ##1 !pin_change_group_one; endsequence
a_reset_pin_override: assert property (!ext_reset_n |-> !pin_oe[7] && pin_pullup[7] && !digital_in_enable[7])
    else $error("reset pin use not overriding drive");
a_reset_from_pin: assert property (!ext_reset_n |-> |p7lo[6:1])
    else $error("reset output low without low pin");
a_irq_from_pin: assert property (external_irq_zero |-> |p6hi[6:1])
    else $error("interrupt zero high without high pin");
a_tmr_from_pin: assert property (timer_zero_ext_clock |-> |p6hi[6:1])
    else $error("timer clock high without high pin");
a_grp_zero_pulse: assert property (pin_change_group_zero |-> s_after0)
    else $error("group zero pulse without low pin change");
a_grp_one_pulse: assert property (pin_change_group_one |-> s_after1)
    else $error("group one pulse without high pin change");
a_awready_pulse: assert property (s_axi_awready |-> s_axi_awvalid ##1 !s_axi_awready)
    else $error("awready not a single taken pulse");
a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
endmodule // pbmux_properties
bind pbmux_top pbmux_properties u_props (.*);

/* dv/pbmux_top_bench.sv */
// self-checking bench for the port b function mux
`timescale 1ns/1ps
`include "pbmux_regs.vh"
module pbmux_top_bench;
    reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    reg         sleep_mode, timer_one_compare_a_out, timer_one_compare_b_out, usi_clock_out, usi_data_out;
    reg  [7:0]  s_axi_awaddr, s_axi_araddr, pin_in;
    reg  [31:0] s_axi_wdata, rdat;
    reg  [3:0]  s_axi_wstrb;
    reg  [1:0]  resp;
    reg  [39:0] rows [0:11];
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [7:0]  pin_out, pin_oe, pin_pullup, digital_in_enable;
    wire        external_irq_zero, timer_zero_ext_clock, usi_serial_in, ext_reset_n;
    wire        pin_change_group_zero, pin_change_group_one;
    integer     err_total, comparisons, cnt0, cnt1, i;
    pbmux_top dut (.*);
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (pin_change_group_zero === 1'b1) cnt0 <= cnt0 + 1;
        if (pin_change_group_one === 1'b1) cnt1 <= cnt1 + 1;
    end
////////////////////////////////////////////////////////////
    task check(input [31:0] seen, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[FAIL] %0t ns: seen %h, expected %h", $time, seen, exp);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("comparisons %0d, mismatches %0d", comparisons, err_total);
            if (err_total == 0 && comparisons > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task stall;
        begin
            err_total = err_total + 1;
            $display("[FAIL] %0t ns: no bus answer", $time);
            tally_and_finish;
        end
    endtask
    // one more edge at the end so no strobe is driven twice in one step
    task wr(input [7:0] a, input [7:0] d);
        integer n;
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= {24'h0, d};
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
            for (n = 0; n < 40; n = n + 1) begin
                @(posedge aclk);
                if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
                if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid === 1'b1) begin
                    resp = s_axi_bresp;
                    s_axi_bready <= 1'b0;
                    n = 50;
                end
            end
            if (n < 50) stall;
            @(posedge aclk);
        end
    endtask
    task rd(input [7:0] a);
        integer n;
        begin
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'b11;
            for (n = 0; n < 40; n = n + 1) begin
                @(posedge aclk);
                if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid === 1'b1) begin
                    rdat = s_axi_rdata;
                    resp = s_axi_rresp;
                    s_axi_rready <= 1'b0;
                    n = 50;
                end
            end
            if (n < 50) stall;
            @(posedge aclk);
        end
    endtask
    task pc(input [7:0] m, input [31:0] e0, input [31:0] e1);
        integer b0, b1;
        begin
            b0 = cnt0;
            b1 = cnt1;
            pin_in <= pin_in ^ m;
            repeat (10) @(posedge aclk);
            check(cnt0 - b0, e0);
            check(cnt1 - b1, e1);
        end
    endtask
////////////////////////////////////////////////////////////
    initial begin
        {err_total, comparisons, cnt0, cnt1} = 128'h0;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sleep_mode} = 7'h00;
        {timer_one_compare_a_out, timer_one_compare_b_out, usi_clock_out, usi_data_out} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        pin_in = 8'h80;
        // clock cfg, dir, data, expected oe, expected pull-up
        rows[0] = 40'h00_ff_a5_ff_00;
        rows[1] = 40'h00_00_ff_00_ff;
        rows[2] = 40'h01_ff_ff_ef_00;
        rows[3] = 40'h01_00_ff_00_ef;
        rows[4] = 40'h02_ff_5a_ff_00;
        rows[5] = 40'h02_00_ff_00_ff;
        rows[6] = 40'h03_ff_ff_cf_00;
        rows[7] = 40'h03_00_ff_00_cf;
        rows[8] = 40'h10_ff_ff_7f_80;
        rows[9] = 40'h10_00_ff_00_ff;
        rows[10] = 40'h13_ff_ff_4f_80;
        rows[11] = 40'h13_00_ff_00_cf;
        // two edges: every flop of the mux resets to a constant; prev_in, p7lo and p6hi in the properties do not
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 12; i = i + 1) begin
            wr(`PBMUX_CLOCK_CFG, rows[i][39:32]);
            wr(`PBMUX_PORT_DIR, rows[i][31:24]);
            wr(`PBMUX_PORT_DATA, rows[i][23:16]);
            repeat (2) @(posedge aclk);
            check(pin_oe, rows[i][15:8]);
            check(pin_pullup, rows[i][7:0]);
            check(pin_out & rows[i][15:8], rows[i][23:16] & rows[i][15:8]);
        end
        $display("- override rows done");
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        check(pin_oe, 8'h00);
        check(ext_reset_n, 1'b1);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`PBMUX_CLOCK_CFG);
        check(rdat, 32'h10);
        rd(8'h24);
        check(resp, `PBMUX_RESP_SLVERR);
        check(rdat, 32'h0);
        wr(`PBMUX_PIN_IN, 8'hff);
        check(resp, `PBMUX_RESP_SLVERR);
        $display("- reset and bus refusal done");
        wr(`PBMUX_CLOCK_CFG, 8'h00);
        wr(`PBMUX_PORT_DIR, 8'hff);
        wr(`PBMUX_IRQ_MASK, 8'h31);
        pc(8'h08, 1, 0);
        pc(8'h80, 0, 1);
        pc(8'h11, 1, 1);
        wr(`PBMUX_IRQ_MASK, 8'h30);
        pc(8'h08, 0, 0);
        wr(`PBMUX_IRQ_MASK, 8'h11);
        pc(8'h12, 1, 0);
        $display("- pin change groups done");
        wr(`PBMUX_IRQ_MASK, 8'h31);
        wr(`PBMUX_CLOCK_CFG, `PBMUX_CLK_XTAL);
        pc(8'h30, 0, 0);
        wr(`PBMUX_CLOCK_CFG, `PBMUX_CLK_EXT);
        pc(8'h10, 0, 0);
        pc(8'h20, 0, 1);
        wr(`PBMUX_CLOCK_CFG, 8'h00);
        wr(`PBMUX_TIMER_CTRL, 8'h06);
        pc(8'h40, 0, 0);
        check(timer_zero_ext_clock, 1'b1);
        wr(`PBMUX_TIMER_CTRL, 8'h00);
        wr(`PBMUX_IRQ_MASK, 8'h71);
        pc(8'h40, 0, 1);
        check(timer_zero_ext_clock, 1'b0);
        wr(`PBMUX_TIMER_CTRL, 8'h08);
        pc(8'h40, 0, 0);
        check(external_irq_zero, 1'b1);
        $display("- masking functions done");
        wr(`PBMUX_CLOCK_CFG, 8'h10);
        repeat (6) @(posedge aclk);
        check(ext_reset_n, 1'b0);
        pc(8'h80, 0, 0);
        check(ext_reset_n, 1'b1);
        sleep_mode <= 1'b1;
        repeat (3) @(posedge aclk);
        check(digital_in_enable[3], 1'b1);
        check(digital_in_enable[7], 1'b0);
        wr(`PBMUX_IRQ_MASK, 8'h00);
        repeat (2) @(posedge aclk);
        check(digital_in_enable[3], 1'b0);
        sleep_mode <= 1'b0;
        $display("- reset pin and sleep done");
        wr(`PBMUX_IRQ_MASK, 8'h31);
        wr(`PBMUX_PORT_DIR, 8'hff);
        wr(`PBMUX_TIMER_ONE, 8'h0f);
        {timer_one_compare_a_out, timer_one_compare_b_out} <= 2'b11;
        repeat (3) @(posedge aclk);
        check(pin_out[3:0], 4'ha);
        {timer_one_compare_a_out, timer_one_compare_b_out} <= 2'b00;
        repeat (3) @(posedge aclk);
        check(pin_out[3:0], 4'h5);
        pc(8'h08, 0, 0);
        check(usi_serial_in, 1'b1);
        $display("- timer one outputs done");
        tally_and_finish;
    end
endmodule // pbmux_top_bench
